// File: core/gpcb_pkg.sv
// Constants and types for the pin configuration bank.
// Assumes a 250 MHz APB clock; register byte address is four times the index.
package gpcb_pkg;
  localparam int NUM_PINS = 40;
  localparam int CLK_NS = 4;
  localparam int DEB_NS = 64;
  localparam int DEB_CYC = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEB_W = $clog2(DEB_CYC + 1);

  // Register indexes and APB byte addresses
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA_A = 8'h74;
  localparam logic [7:0] IDX_DMA_B = 8'h75;
  localparam logic [7:0] IDX_PIN_SEL = 8'hf0;
  localparam logic [7:0] IDX_PIN_WIN = 8'hf1;
  localparam logic [7:0] IDX_ROUTE = 8'hf2;
  localparam logic [9:0] A_ACT = {IDX_ACT, 2'h0};
  localparam logic [9:0] A_BASE_HI = {IDX_BASE_HI, 2'h0};
  localparam logic [9:0] A_BASE_LO = {IDX_BASE_LO, 2'h0};
  localparam logic [9:0] A_IRQ_NUM = {IDX_IRQ_NUM, 2'h0};
  localparam logic [9:0] A_IRQ_TYPE = {IDX_IRQ_TYPE, 2'h0};
  localparam logic [9:0] A_DMA_A = {IDX_DMA_A, 2'h0};
  localparam logic [9:0] A_DMA_B = {IDX_DMA_B, 2'h0};
  localparam logic [9:0] A_PIN_SEL = {IDX_PIN_SEL, 2'h0};
  localparam logic [9:0] A_PIN_WIN = {IDX_PIN_WIN, 2'h0};
  localparam logic [9:0] A_ROUTE = {IDX_ROUTE, 2'h0};

  // Reset values and field layout
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CFG_EVT = 8'h44;
  localparam logic [7:0] RST_CFG_STD = 8'h04;
  localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
  localparam logic [7:0] DMA_NONE = 8'h04;
  localparam logic [2:0] LAST_PORT = 3'h4;
  localparam int PORT_LSB = 4;
  localparam int ITYPE_WR_BIT = 1;
  localparam int ACT_BIT = 0;

  typedef struct packed {
    logic deb;
    logic pol;
    logic etype;
    logic lock;
    logic pull_up;
    logic push_pull;
    logic out_en;
  } gpcb_pin_cfg_t;

  typedef struct packed {
    logic active;
    logic [15:0] base;
    logic [7:0] irq_num;
    logic [7:0] irq_type;
  } gpcb_ldev_t;

  // Ports 0, 1 and 4 carry event detection
  function automatic logic gpcb_evt_port(logic [2:0] port);
    return (port == 3'h0) || (port == 3'h1) || (port == 3'h4);
  endfunction
endpackage

// File: core/gpcb_bank.sv
// Pin configuration bank of the GPIO logical device, APB slave, with
// per-pin debounce and event detection on ports 0, 1 and 4 feeding the runtime event logic.
// Assumes pin inputs already synchronous to pclk; global config bits arrive
// as plain inputs from the global register block.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module gpcb_bank
  import gpcb_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Global configuration
  input wire logic global_config_one_enable,
  input wire logic global_config_three_mux_lock,
  // Pins and per-pin settings
  input wire logic [NUM_PINS-1:0] pin_in,
  output gpcb_pin_cfg_t [NUM_PINS-1:0] pin_cfg,
  output logic [NUM_PINS-1:0][2:0] pin_route,
  output logic [NUM_PINS-1:0] event_detect,
  output logic mux_change_allowed,
  // Logical device settings
  output gpcb_ldev_t ldev
);
  gpcb_pin_cfg_t cfg_mem [NUM_PINS];
  logic [2:0] route_mem [NUM_PINS];
  logic [7:0] pin_sel;
  logic act;
  logic [7:0] base_hi;
  logic [3:0] base_lo_hi;
  logic [7:0] irq_num;
  logic irq_type_b1;
  logic [7:0] rd_val;
  logic rd_hit;
  logic wr_en;
  logic rd_setup;
  logic [2:0] sel_port;
  logic [5:0] sel_idx;
  logic sel_ok;
  logic sel_evt;
  gpcb_pin_cfg_t cur_cfg;
  logic [NUM_PINS-1:0] lock_vec;
  logic [NUM_PINS-1:0] evt_bits;
  logic [NUM_PINS-1:0] evt_cap;

  // Write takes effect at the access edge; reads are sampled in setup
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;

  assign sel_port = pin_sel[6:4];
  assign sel_idx = {sel_port, pin_sel[2:0]};
  assign sel_ok = (sel_port <= LAST_PORT);
  assign sel_evt = gpcb_evt_port(sel_port);
  assign cur_cfg = sel_ok ? cfg_mem[sel_idx] : '0;

  // Merge a window write into one pin's settings
  function automatic gpcb_pin_cfg_t merge_cfg(gpcb_pin_cfg_t old, logic [7:0] wd,
                                               logic evt);
    gpcb_pin_cfg_t n;
    n = old;
    n.deb = evt & wd[6];
    n.pol = evt & wd[5];
    n.etype = evt & wd[4];
    n.lock = old.lock | wd[3];
    if (!old.lock) begin
      n.pull_up = wd[2];
      n.push_pull = wd[1];
      n.out_en = wd[0];
    end
    return n;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel <= RST_ZERO;
    end else if (wr_en && paddr == A_PIN_SEL) begin
      pin_sel <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_mem[i] <= gpcb_evt_port(3'(i / 8)) ? RST_CFG_EVT[6:0]
                                               : RST_CFG_STD[6:0];
      end
    end else if (wr_en && paddr == A_PIN_WIN && sel_ok) begin
      cfg_mem[sel_idx] <= merge_cfg(cfg_mem[sel_idx], pwdata[7:0], sel_evt);
    end
  end

  // Routing exists only for event ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        route_mem[i] <= RST_ZERO[2:0];
      end
    end else if (wr_en && paddr == A_ROUTE && sel_ok && sel_evt) begin
      route_mem[sel_idx] <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= RST_ZERO[ACT_BIT];
      base_hi <= RST_ZERO;
      base_lo_hi <= RST_ZERO[7:4];
      irq_num <= RST_ZERO;
      irq_type_b1 <= RST_IRQ_TYPE[ITYPE_WR_BIT];
    end else if (wr_en) begin
      if (paddr == A_ACT) begin
        act <= pwdata[ACT_BIT];
      end
      if (paddr == A_BASE_HI) begin
        base_hi <= pwdata[7:0];
      end
      if (paddr == A_BASE_LO) begin
        base_lo_hi <= pwdata[7:4];
      end
      if (paddr == A_IRQ_NUM) begin
        irq_num <= pwdata[7:0];
      end
      if (paddr == A_IRQ_TYPE) begin
        irq_type_b1 <= pwdata[ITYPE_WR_BIT];
      end
    end
  end

  // Only bit 0 of activation is kept; the rest read zero
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      A_ACT: rd_val = {7'h0, act};
      A_BASE_HI: rd_val = base_hi;
      A_BASE_LO: rd_val = {base_lo_hi, 4'h0};
      A_IRQ_NUM: rd_val = irq_num;
      A_IRQ_TYPE: rd_val = {RST_IRQ_TYPE[7:2], irq_type_b1, RST_IRQ_TYPE[0]};
      A_DMA_A: rd_val = DMA_NONE;
      A_DMA_B: rd_val = DMA_NONE;
      A_PIN_SEL: rd_val = pin_sel;
      A_PIN_WIN: rd_val = {1'b0, cur_cfg};
      A_ROUTE: rd_val = (sel_ok && sel_evt) ? {5'h0, route_mem[sel_idx]} : 8'h00;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data is registered in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0 : {24'h0, rd_val};
      pslverr <= !rd_hit;
    end
  end

  // Device is active only when both enables are set
  assign ldev.active = act & global_config_one_enable;
  assign ldev.base = {base_hi, base_lo_hi, 4'h0};
  assign ldev.irq_num = irq_num;
  assign ldev.irq_type = {RST_IRQ_TYPE[7:2], irq_type_b1, RST_IRQ_TYPE[0]};
  // Pin lock deliberately left out: multiplexing has its own lock
  assign mux_change_allowed = !global_config_three_mux_lock;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    assign pin_cfg[g] = cfg_mem[g];
    assign pin_route[g] = route_mem[g];
    assign lock_vec[g] = cfg_mem[g].lock;
    assign evt_bits[g] = cfg_mem[g].deb | cfg_mem[g].pol | cfg_mem[g].etype;
    assign evt_cap[g] = gpcb_evt_port(3'(g / 8));
    if (gpcb_evt_port(3'(g / 8))) begin : g_evt
      logic filt;
      logic filt_d;
      logic [DEB_W-1:0] cnt;
      logic act_lvl;
      logic act_d;
      // Counter restarts whenever the input agrees with the filtered level
      // Filter starts high: pull-ups are on after reset, so the pin idles high
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt <= 1'b1;
          cnt <= '0;
        end else if (!cfg_mem[g].deb || pin_in[g] == filt) begin
          filt <= pin_in[g];
          cnt <= '0;
        end else if (cnt == DEB_W'(DEB_CYC - 1)) begin
          filt <= pin_in[g];
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
      assign act_lvl = cfg_mem[g].pol ? filt : !filt;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_d <= 1'b0;
          filt_d <= 1'b1;
        end else begin
          act_d <= act_lvl;
          filt_d <= filt;
        end
      end
      // Edge is gated by a real filtered transition so a polarity flip
      // does not fake an edge
      assign event_detect[g] = cfg_mem[g].etype ? act_lvl
                               : (act_lvl && !act_d && filt != filt_d);
    end else begin : g_std
      assign event_detect[g] = 1'b0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr(logic [9:0] a);
    psel && penable && pwrite && pstrb[0] && paddr == a;
  endsequence

  sequence s_rd_setup(logic [9:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  chk_sel_write_fields: assert property (s_wr(A_PIN_SEL) |=>
    pin_sel == {1'b0, $past(pwdata[6:4]), 1'b0, $past(pwdata[2:0])})
    else $error("pin select did not take written port and pin");

  chk_sel_reserved_zero: assert property (!pin_sel[7] && !pin_sel[3])
    else $error("pin select reserved bit set");

  chk_bad_port_read: assert property (s_rd_setup(A_PIN_WIN) ##0 (pin_sel[6:4] > LAST_PORT)
    |=> prdata == 32'h0)
    else $error("reserved port code read nonzero");

  chk_window_lock_set: assert property (s_wr(A_PIN_WIN) ##0 sel_ok |=>
    cur_cfg.lock == ($past(cur_cfg.lock) | $past(pwdata[3])))
    else $error("window write did not reach selected pin");

  chk_cfg_reset_values: assert property ($rose(presetn) |->
    cfg_mem[0] == RST_CFG_EVT[6:0] && cfg_mem[16] == RST_CFG_STD[6:0])
    else $error("pin settings wrong after reset");

  chk_lock_sticky_bits: assert property (($past(lock_vec) & ~lock_vec) == '0)
    else $error("lock bit cleared without reset");

  chk_lock_freeze_out: assert property (s_wr(A_PIN_WIN) ##0 cur_cfg.lock |=>
    $stable({cur_cfg.pull_up, cur_cfg.push_pull, cur_cfg.out_en}))
    else $error("locked pin output settings changed");

  chk_noevt_bits_zero: assert property ((evt_bits & ~evt_cap) == '0)
    else $error("event bits set on port without detection");

  chk_base_low_align: assert property (s_wr(A_BASE_LO) |=>
    ldev.base[7:4] == $past(pwdata[7:4]) && ldev.base[3:0] == 4'h0)
    else $error("base low write wrong or unaligned");

  chk_irq_type_write: assert property (s_wr(A_IRQ_TYPE) |=>
    ldev.irq_type == {6'h0, $past(pwdata[1]), 1'b1})
    else $error("interrupt type wrote a read-only bit");

  chk_dma_report_read: assert property ((s_rd_setup(A_DMA_A) or s_rd_setup(A_DMA_B))
    |=> prdata == {24'h0, DMA_NONE} && !pslverr)
    else $error("DMA report not 04h");

  chk_active_gate: assert property (s_wr(A_ACT) ##1 global_config_one_enable
    |-> ldev.active == $past(pwdata[0], 2))
    else $error("activation not applied");

  chk_mux_free_lock: assert property ((|lock_vec) && !global_config_three_mux_lock
    |-> mux_change_allowed)
    else $error("pin lock froze multiplexing");

  chk_level_event_hi: assert property (
    (!cfg_mem[0].deb && cfg_mem[0].etype && cfg_mem[0].pol && pin_in[0]) [*2]
    |-> event_detect[0])
    else $error("rising level event missed");

  chk_debounce_hold: assert property (cfg_mem[0].deb && $changed(pin_in[0])
    |=> $stable(g_pin[0].g_evt.filt))
    else $error("debounce passed a fresh change");
endmodule

// File: testbench/test_gpio_pin_config_bank.sv
// Self-checking bench for the pin configuration bank.
// Drives the APB port, the global config bits and pin levels directly.
`timescale 1ns/1ns
module test_gpio_pin_config_bank;
  import gpcb_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, g_en, g_mux, mux_ok, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [NUM_PINS-1:0] pin_in, event_detect;
  gpcb_pin_cfg_t [NUM_PINS-1:0] pin_cfg;
  logic [NUM_PINS-1:0][2:0] pin_route;
  gpcb_ldev_t ldev;
  int failures = 0;
  int n_compared = 0;

  gpcb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .global_config_one_enable(g_en),
    .global_config_three_mux_lock(g_mux), .pin_in(pin_in), .pin_cfg(pin_cfg),
    .pin_route(pin_route), .event_detect(event_detect),
    .mux_change_allowed(mux_ok), .ldev(ldev));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      results();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // Counts cycles with an event on pin 0, sampled mid-cycle once settled
  task automatic evcount(input int n, input int e);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge pclk);
      if (event_detect[0] === 1'b1) c++;
    end
    @(posedge pclk);
    chk(c, e);
  endtask

  task automatic t_reset();
    rchk(A_ACT, 8'h00);
    rchk(A_BASE_HI, 8'h00);
    rchk(A_BASE_LO, 8'h00);
    rchk(A_IRQ_NUM, 8'h00);
    rchk(A_IRQ_TYPE, 8'h03);
    rchk(A_DMA_A, 8'h04);
    rchk(A_DMA_B, 8'h04);
    rchk(A_PIN_SEL, 8'h00);
    rchk(A_PIN_WIN, 8'h44);
    chk(pin_cfg[16], 32'h04);
    chk(pin_cfg[32], 32'h44);
    $display("test reset done");
  endtask

  task automatic t_select();
    logic [7:0] e;
    for (int p = 0; p < 5; p++) begin
      e = (p == 2 || p == 3) ? 8'h04 : 8'h44;
      wr(A_PIN_SEL, {1'b0, 3'(p), 4'h7});
      rchk(A_PIN_WIN, e);
    end
    wr(A_PIN_SEL, 8'hff);
    rchk(A_PIN_SEL, 8'h77);
    rchk(A_PIN_WIN, 8'h00);
    wr(A_PIN_SEL, 8'h25);
    wr(A_PIN_WIN, 8'hf7);
    rchk(A_PIN_WIN, 8'h07);
    chk(pin_cfg[21], 32'h07);
    // Routing is absent on ports without event detection
    wr(A_ROUTE, 8'hff);
    rchk(A_ROUTE, 8'h00);
    chk(pin_route[21], 32'h0);
    wr(A_PIN_SEL, 8'h12);
    wr(A_ROUTE, 8'hfd);
    rchk(A_ROUTE, 8'h05);
    chk(pin_route[10], 32'h5);
    $display("test select done");
  endtask

  task automatic t_lock();
    wr(A_PIN_SEL, 8'h03);
    wr(A_PIN_WIN, 8'h0b);
    rchk(A_PIN_WIN, 8'h0b);
    wr(A_PIN_WIN, 8'h70);
    rchk(A_PIN_WIN, 8'h7b);
    chk(pin_cfg[3], 32'h7b);
    chk(mux_ok, 32'h1);
    g_mux <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    chk(mux_ok, 32'h0);
    g_mux <= 1'b0;
    // Only a reset may clear the lock
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_PIN_SEL, 8'h00);
    wr(A_PIN_SEL, 8'h03);
    rchk(A_PIN_WIN, 8'h44);
    $display("test lock done");
  endtask

  task automatic t_ldev();
    wr(A_BASE_LO, 8'hff);
    rchk(A_BASE_LO, 8'hf0);
    wr(A_BASE_HI, 8'h12);
    rchk(A_BASE_HI, 8'h12);
    chk(ldev.base, 32'h12f0);
    wr(A_IRQ_NUM, 8'h05);
    rchk(A_IRQ_NUM, 8'h05);
    chk(ldev.irq_num, 32'h05);
    wr(A_IRQ_TYPE, 8'h00);
    rchk(A_IRQ_TYPE, 8'h01);
    chk(ldev.irq_type, 32'h01);
    wr(A_IRQ_TYPE, 8'hff);
    rchk(A_IRQ_TYPE, 8'h03);
    chk(ldev.irq_type, 32'h03);
    wr(A_DMA_B, 8'h00);
    rchk(A_DMA_B, 8'h04);
    wr(A_ACT, 8'h01);
    rchk(A_ACT, 8'h01);
    chk(ldev.active, 32'h1);
    g_en <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk(ldev.active, 32'h0);
    g_en <= 1'b1;
    apb(1'b0, 10'h004, 8'h00);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test device done");
  endtask

  task automatic t_event();
    wr(A_PIN_SEL, 8'h00);
    wr(A_PIN_WIN, 8'h04);
    pin_in[0] <= 1'b0;
    evcount(10, 1);
    pin_in[0] <= 1'b1;
    evcount(10, 0);
    wr(A_PIN_WIN, 8'h24);
    pin_in[0] <= 1'b0;
    evcount(10, 0);
    pin_in[0] <= 1'b1;
    evcount(10, 1);
    wr(A_PIN_WIN, 8'h34);
    repeat (3) @(posedge pclk);
    evcount(10, 10);
    pin_in[0] <= 1'b0;
    repeat (3) @(posedge pclk);
    evcount(10, 0);
    // Low level type with the pin held low
    wr(A_PIN_WIN, 8'h14);
    repeat (3) @(posedge pclk);
    evcount(10, 10);
    pin_in[0] <= 1'b1;
    wr(A_PIN_WIN, 8'h44);
    repeat (20) @(posedge pclk);
    // Glitch shorter than the debounce period
    pin_in[0] <= 1'b0;
    repeat (8) @(posedge pclk);
    pin_in[0] <= 1'b1;
    evcount(30, 0);
    pin_in[0] <= 1'b0;
    evcount(12, 0);
    evcount(12, 1);
    $display("test event done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    g_en = 1'b1;
    g_mux = 1'b0;
    pin_in = '1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_select();
    t_lock();
    t_ldev();
    t_event();
    results();
  end
endmodule
